// ===== common/pstg_pkg.sv
// Package of constants and types for the modulator synchronisation, trip and trigger glue.
package pstg_pkg;

  // ---------------------------------------------------------------------------
  // Structure
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_MODULES     = 9;  // Modulator modules in the chain.
  localparam int unsigned NUM_FINE        = 8;  // Modules with fine edge placement.
  localparam int unsigned NUM_GEN_TRIPS   = 15; // General trip inputs per module.
  localparam int unsigned NUM_PIN_TRIPS   = 12; // Pin-trip signals from the pin multiplexer.
  localparam int unsigned NUM_ZONE_TRIPS  = 6;  // Active-low zone trip inputs.
  localparam int unsigned NUM_CONV_STARTS = 18; // Unmerged conversion-start outputs.

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned SYNC_STRETCH_CYC = 8;  // Sync output stretch, clock cycles.
  localparam int unsigned CONV_STRETCH_CYC = 32; // Conversion-start stretch, clock cycles.
  localparam int unsigned STRETCH_CNT_W    = 6;  // Wide enough for the longest stretch.
  localparam int unsigned USTEP_TYP_PS     = 150; // Typical micro edge step.
  localparam int unsigned USTEP_MAX_PS     = 310; // Largest micro edge step.
  localparam int unsigned CLK_PERIOD_PS    = 25000;
  // Most micro steps that fit within one clock period at the largest step.
  localparam int unsigned USTEPS_PER_CLK   = CLK_PERIOD_PS / USTEP_MAX_PS;
  localparam int unsigned USTEP_W          = 7;

  // ---------------------------------------------------------------------------
  // Trip action encoding
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PSTG_TRIP_HIGHZ   = 2'h0,
    PSTG_TRIP_HIGH    = 2'h1,
    PSTG_TRIP_LOW     = 2'h2,
    PSTG_TRIP_NOTHING = 2'h3
  } pstg_trip_act_t;

  localparam int unsigned PERIOD_W = 16; // Time-base period width.

endpackage : pstg_pkg

// ===== src/pstg_stretch.sv
// Retriggerable pulse stretcher with a fixed output length.
`timescale 1ns/1ps
`default_nettype none

module pstg_stretch #(
  parameter int unsigned LEN = 8
) (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic pulse_i,
  output var  logic stretched_o
);
  import pstg_pkg::*;

  localparam logic [STRETCH_CNT_W-1:0] LOAD = STRETCH_CNT_W'(LEN);

  logic [STRETCH_CNT_W-1:0] cnt_q;

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  // A new input reloads the count, so the output ends LEN cycles after the last one.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else if (pulse_i) begin
      cnt_q <= LOAD;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - STRETCH_CNT_W'(1);
    end
  end

  assign stretched_o = (cnt_q != '0);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_stretch_length: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    pulse_i ##1 (!pulse_i) [*1] |-> stretched_o)
    else $error("Stretch output dropped after a pulse.");
  a_stretch_end: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $fell(stretched_o) |-> $past(cnt_q) == STRETCH_CNT_W'(1))
    else $error("Stretch ended before the count ran out.");

endmodule // pstg_stretch
`default_nettype wire

// ===== src/pstg_modulator.sv
// One modulator module: time base, compare, fine edge, sync and trip handling.
`timescale 1ns/1ps
`default_nettype none

module pstg_modulator #(
  parameter bit FINE = 1'b1
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          tb_enable_i,
  input  wire logic                          sync_in_i,
  input  wire logic [pstg_pkg::PERIOD_W-1:0] period_i,
  input  wire logic [pstg_pkg::PERIOD_W-1:0] cmp_a_i,
  input  wire logic [pstg_pkg::PERIOD_W-1:0] cmp_b_i,
  input  wire logic [pstg_pkg::USTEP_W-1:0]  ustep_a_i,
  input  wire logic [pstg_pkg::USTEP_W-1:0]  ustep_b_i,
  input  wire logic                          trip_any_i,
  input  wire pstg_pkg::pstg_trip_act_t      act_a_i,
  input  wire pstg_pkg::pstg_trip_act_t      act_b_i,
  input  wire logic                          trip_clear_i,
  output var  logic                          out_a_o,
  output var  logic                          out_b_o,
  output var  logic                          oe_a_o,
  output var  logic                          oe_b_o,
  output var  logic [pstg_pkg::USTEP_W-1:0]  edge_a_o,
  output var  logic [pstg_pkg::USTEP_W-1:0]  edge_b_o,
  output var  logic                          sync_out_o,
  output var  logic                          conv_start_a_o,
  output var  logic                          conv_start_b_o,
  output var  logic                          event_irq_o,
  output var  logic                          trip_irq_o
);
  import pstg_pkg::*;

  logic [PERIOD_W-1:0] ctr_q;
  logic                tripped_q;
  logic                wave_a_q, wave_b_q;

  // ---------------------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------------------
  // Counter runs only while the global sync enable is set, and restarts on sync.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctr_q <= '0;
    end else if (!tb_enable_i || sync_in_i || ctr_q >= period_i) begin
      ctr_q <= '0;
    end else begin
      ctr_q <= ctr_q + PERIOD_W'(1);
    end
  end

  // Waveforms rise at zero and fall at compare; events are registered pulses.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wave_a_q       <= 1'b0;
      wave_b_q       <= 1'b0;
      sync_out_o     <= 1'b0;
      conv_start_a_o <= 1'b0;
      conv_start_b_o <= 1'b0;
      event_irq_o    <= 1'b0;
    end else begin
      wave_a_q       <= tb_enable_i && (ctr_q < cmp_a_i);
      wave_b_q       <= tb_enable_i && (ctr_q < cmp_b_i);
      sync_out_o     <= tb_enable_i && (ctr_q == '0);
      conv_start_a_o <= tb_enable_i && (ctr_q == cmp_a_i);
      conv_start_b_o <= tb_enable_i && (ctr_q == cmp_b_i);
      event_irq_o    <= tb_enable_i && (ctr_q == period_i);
    end
  end

  // ---------------------------------------------------------------------------
  // Trip latch
  // ---------------------------------------------------------------------------
  // Trip holds until recovery clears it; a trip in the clear cycle wins.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tripped_q  <= 1'b0;
      trip_irq_o <= 1'b0;
    end else begin
      tripped_q  <= trip_any_i || (tripped_q && !trip_clear_i);
      trip_irq_o <= trip_any_i && !tripped_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Output forcing and fine edge
  // ---------------------------------------------------------------------------
  // Trip acts in the same cycle it arrives, so forcing does not wait a clock.
  function automatic logic [1:0] force_out(input logic trip, input pstg_trip_act_t act, input logic wave);
    logic [1:0] r;
    r = {1'b1, wave};
    if (trip) begin
      case (act)
        PSTG_TRIP_HIGHZ: r = 2'b00;
        PSTG_TRIP_HIGH:  r = 2'b11;
        PSTG_TRIP_LOW:   r = 2'b10;
        default:         r = {1'b1, wave};
      endcase
    end
    return r;
  endfunction

  logic trip_now;
  assign trip_now = trip_any_i || tripped_q;
  assign {oe_a_o, out_a_o} = force_out(trip_now, act_a_i, wave_a_q);
  assign {oe_b_o, out_b_o} = force_out(trip_now, act_b_i, wave_b_q);

  // Micro step offset goes to the delay line; the standard module has none.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      edge_a_o <= '0;
      edge_b_o <= '0;
    end else begin
      edge_a_o <= FINE && (ustep_a_i < USTEP_W'(USTEPS_PER_CLK)) ? ustep_a_i : '0;
      edge_b_o <= FINE && (ustep_b_i < USTEP_W'(USTEPS_PER_CLK)) ? ustep_b_i : '0;
    end
  end

  a_trip_holds: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    tripped_q && !trip_clear_i |=> tripped_q)
    else $error("Trip released without recovery.");
  a_trip_forces: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    trip_any_i && act_a_i == PSTG_TRIP_LOW |-> oe_a_o && !out_a_o)
    else $error("Trip did not force output low.");
  a_trip_highz: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    trip_any_i && act_b_i == PSTG_TRIP_HIGHZ |-> !oe_b_o)
    else $error("Trip did not release the output.");
  a_std_no_fine: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !FINE |-> edge_a_o == '0)
    else $error("Standard module produced a fine edge.");

endmodule // pstg_modulator
`default_nettype wire

// ===== src/pstg_glue.sv
// Top of the modulator glue: sync, trip sources, trigger merge and interrupt fan-out.
//
// How it works
// - Fine modules place edges in micro steps.
// - Nine modules: eight fine, one standard.
// - Sync from pin trip one; enable from control.
// - First module sync out stretched eight cycles.
// - General trips: twelve pins, ECC, expander error.
// - Zone trips: three pins, encoder, clock, halt.
// - A starts ORed, stretched 32, to mux.
// - B starts ORed, stretched 32, to mux.
// - All eighteen starts go to converter.
// - Each module has event and trip interrupts.
// - Trip forces output high, low or released.
`timescale 1ns/1ps
`default_nettype none

module pstg_glue (
  input  wire logic                                          sys_clk_i,
  input  wire logic                                          rstn_i,
  input  wire logic [pstg_pkg::NUM_PIN_TRIPS-1:0]            pin_trip_source_i,
  input  wire logic                                          periph_clock_ctrl_reg0_tbsync_i,
  input  wire logic                                          ram_double_bit_error_i,
  input  wire logic                                          interrupt_expander_error_i,
  input  wire logic                                          encoder_unit_error_i,
  input  wire logic                                          clock_loss_detect_i,
  input  wire logic                                          debug_halt_i,
  input  wire logic [pstg_pkg::NUM_MODULES*pstg_pkg::PERIOD_W-1:0] period_i,
  input  wire logic [pstg_pkg::NUM_MODULES*pstg_pkg::PERIOD_W-1:0] cmp_a_i,
  input  wire logic [pstg_pkg::NUM_MODULES*pstg_pkg::PERIOD_W-1:0] cmp_b_i,
  input  wire logic [pstg_pkg::NUM_MODULES*pstg_pkg::USTEP_W-1:0]  ustep_a_i,
  input  wire logic [pstg_pkg::NUM_MODULES*pstg_pkg::USTEP_W-1:0]  ustep_b_i,
  input  wire logic [pstg_pkg::NUM_MODULES*pstg_pkg::NUM_GEN_TRIPS-1:0] gen_trip_en_i,
  input  wire logic [pstg_pkg::NUM_MODULES*pstg_pkg::NUM_ZONE_TRIPS-1:0] zone_trip_en_i,
  input  wire logic [pstg_pkg::NUM_MODULES*2-1:0]            act_a_i,
  input  wire logic [pstg_pkg::NUM_MODULES*2-1:0]            act_b_i,
  input  wire logic [pstg_pkg::NUM_MODULES-1:0]              trip_clear_i,
  output var  logic [pstg_pkg::NUM_MODULES-1:0]              out_a_o,
  output var  logic [pstg_pkg::NUM_MODULES-1:0]              out_b_o,
  output var  logic [pstg_pkg::NUM_MODULES-1:0]              oe_a_o,
  output var  logic [pstg_pkg::NUM_MODULES-1:0]              oe_b_o,
  output var  logic [pstg_pkg::NUM_MODULES*pstg_pkg::USTEP_W-1:0]  edge_a_o,
  output var  logic [pstg_pkg::NUM_MODULES*pstg_pkg::USTEP_W-1:0]  edge_b_o,
  output var  logic                                          first_module_sync_out_o,
  output var  logic                                          merged_conv_start_a_o,
  output var  logic                                          merged_conv_start_b_o,
  output var  logic [pstg_pkg::NUM_CONV_STARTS-1:0]          conv_start_o,
  output var  logic [pstg_pkg::NUM_MODULES-1:0]              modulator_event_irq_o,
  output var  logic [pstg_pkg::NUM_MODULES-1:0]              modulator_trip_irq_o
);
  import pstg_pkg::*;

  // ---------------------------------------------------------------------------
  // Trip sources
  // ---------------------------------------------------------------------------
  logic                      ext_sync_in;
  logic                      timebase_clock_sync_enable;
  logic [NUM_GEN_TRIPS-1:0]  general_trip_inputs;
  logic [NUM_ZONE_TRIPS-1:0] zone_trip_inputs_n; // Active low.
  logic [NUM_MODULES-1:0]    sync_out, conv_start_a, conv_start_b;

  // Pin trip one drives the chain sync; the clock control bit gates all time bases.
  assign ext_sync_in                = pin_trip_source_i[0];
  assign timebase_clock_sync_enable = periph_clock_ctrl_reg0_tbsync_i;

  // Twelve pin trips then the two fault lines fill the general group; top input unused.
  assign general_trip_inputs = {1'b0, interrupt_expander_error_i, ram_double_bit_error_i,
                                pin_trip_source_i};

  // Zone trips are active low, so each fault is inverted onto its line.
  assign zone_trip_inputs_n = ~{debug_halt_i, clock_loss_detect_i, encoder_unit_error_i,
                                pin_trip_source_i[2:0]};

  // ---------------------------------------------------------------------------
  // Modules
  // ---------------------------------------------------------------------------
  // Module zero is the first module; the last index is the standard one.
  for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
    logic trip_any;
    assign trip_any = |(general_trip_inputs & gen_trip_en_i[m*NUM_GEN_TRIPS +: NUM_GEN_TRIPS])
                   || |(~zone_trip_inputs_n & zone_trip_en_i[m*NUM_ZONE_TRIPS +: NUM_ZONE_TRIPS]);
    pstg_modulator #(
      .FINE (m < NUM_FINE)
    ) u_mod (
      .sys_clk_i      (sys_clk_i),
      .rstn_i         (rstn_i),
      .tb_enable_i    (timebase_clock_sync_enable),
      .sync_in_i      (m == 0 ? ext_sync_in : sync_out[0]),
      .period_i       (period_i[m*PERIOD_W +: PERIOD_W]),
      .cmp_a_i        (cmp_a_i[m*PERIOD_W +: PERIOD_W]),
      .cmp_b_i        (cmp_b_i[m*PERIOD_W +: PERIOD_W]),
      .ustep_a_i      (ustep_a_i[m*USTEP_W +: USTEP_W]),
      .ustep_b_i      (ustep_b_i[m*USTEP_W +: USTEP_W]),
      .trip_any_i     (trip_any),
      .act_a_i        (pstg_trip_act_t'(act_a_i[m*2 +: 2])),
      .act_b_i        (pstg_trip_act_t'(act_b_i[m*2 +: 2])),
      .trip_clear_i   (trip_clear_i[m]),
      .out_a_o        (out_a_o[m]),
      .out_b_o        (out_b_o[m]),
      .oe_a_o         (oe_a_o[m]),
      .oe_b_o         (oe_b_o[m]),
      .edge_a_o       (edge_a_o[m*USTEP_W +: USTEP_W]),
      .edge_b_o       (edge_b_o[m*USTEP_W +: USTEP_W]),
      .sync_out_o     (sync_out[m]),
      .conv_start_a_o (conv_start_a[m]),
      .conv_start_b_o (conv_start_b[m]),
      .event_irq_o    (modulator_event_irq_o[m]),
      .trip_irq_o     (modulator_trip_irq_o[m])
    );
    // Each module's pair goes unmerged to the converter trigger select.
    assign conv_start_o[2*m]   = conv_start_a[m];
    assign conv_start_o[2*m+1] = conv_start_b[m];
  end

  // ---------------------------------------------------------------------------
  // Stretchers
  // ---------------------------------------------------------------------------
  // Module outputs are one cycle; the pin mux needs longer pulses to see them.
  pstg_stretch #(.LEN(SYNC_STRETCH_CYC)) u_sync_str (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .pulse_i     (sync_out[0]),
    .stretched_o (first_module_sync_out_o)
  );
  pstg_stretch #(.LEN(CONV_STRETCH_CYC)) u_start_a_str (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .pulse_i     (|conv_start_a),
    .stretched_o (merged_conv_start_a_o)
  );
  pstg_stretch #(.LEN(CONV_STRETCH_CYC)) u_start_b_str (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .pulse_i     (|conv_start_b),
    .stretched_o (merged_conv_start_b_o)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_sync_stretch: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    sync_out[0] |=> first_module_sync_out_o [*8])
    else $error("Sync output not held for eight cycles.");
  a_start_a_merge: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    |conv_start_a |=> merged_conv_start_a_o [*8])
    else $error("Merged A start not raised.");
  a_start_b_merge: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    |conv_start_b |=> merged_conv_start_b_o [*8])
    else $error("Merged B start not raised.");
  a_conv_route: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    conv_start_o[1] == conv_start_b[0])
    else $error("Conversion start routing wrong.");
  a_zone_trip: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    debug_halt_i |-> !zone_trip_inputs_n[5])
    else $error("Halt did not pull its zone line low.");
  a_sync_source: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    ext_sync_in == pin_trip_source_i[0])
    else $error("Sync not sourced from pin trip one.");

  c_sync_out:  cover property (@(posedge sys_clk_i) disable iff (!rstn_i) $fell(first_module_sync_out_o));
  c_start_a:   cover property (@(posedge sys_clk_i) disable iff (!rstn_i) $fell(merged_conv_start_a_o));
  c_trip_irq:  cover property (@(posedge sys_clk_i) disable iff (!rstn_i) |modulator_trip_irq_o);

endmodule // pstg_glue
`default_nettype wire

// ===== testbench/pstg_far_model.sv
// Far-side model of the pin multiplexer that measures each stretched pulse it receives.
`timescale 1ns/1ps
`default_nettype none

module pstg_far_model (
  input  wire logic            sys_clk_i,
  input  wire logic            rstn_i,
  input  wire logic            sync_i,
  input  wire logic            start_a_i,
  input  wire logic            start_b_i,
  output var  logic [2:0][7:0] width_o
);
  logic [2:0][7:0] run_q;
  logic [2:0]      lvl;

  assign lvl = {start_b_i, start_a_i, sync_i};

  // The mux sees only levels, so it latches the length of each high run when the run ends.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_q   <= '0;
      width_o <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (lvl[i]) begin
          run_q[i] <= run_q[i] + 8'h01;
        end else if (run_q[i] != 8'h00) begin
          width_o[i] <= run_q[i];
          run_q[i]   <= 8'h00;
        end
      end
    end
  end
endmodule // pstg_far_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the modulator glue: triggers, sync, trips and micro steps.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic            sys_clk_i = 1'b0;
  logic            rstn_i = 1'b0;
  logic [11:0]     pin_trip_source_i = '0;
  logic            periph_clock_ctrl_reg0_tbsync_i = 1'b1;
  logic            ram_double_bit_error_i = 1'b0;
  logic            interrupt_expander_error_i = 1'b0;
  logic            encoder_unit_error_i = 1'b0;
  logic            clock_loss_detect_i = 1'b0;
  logic            debug_halt_i = 1'b0;
  logic [143:0]    period_i = {9{16'h003f}};
  logic [143:0]    cmp_a_i = '1;
  logic [143:0]    cmp_b_i = '1;
  logic [62:0]     ustep_a_i = '0;
  logic [62:0]     ustep_b_i = '0;
  logic [134:0]    gen_trip_en_i = '0;
  logic [53:0]     zone_trip_en_i = '0;
  logic [17:0]     act_a_i = '1;
  logic [17:0]     act_b_i = '1;
  logic [8:0]      trip_clear_i = '0;
  logic [8:0]      out_a_o, out_b_o, oe_a_o, oe_b_o, modulator_event_irq_o, modulator_trip_irq_o;
  logic [62:0]     edge_a_o, edge_b_o;
  logic            first_module_sync_out_o, merged_conv_start_a_o, merged_conv_start_b_o;
  logic [17:0]     conv_start_o;
  logic [2:0][7:0] width;
  int              errors = 0;
  int              check_count = 0;
  int              cycle_count = 0;

  pstg_glue pstg_glue_i (.sys_clk_i, .rstn_i, .pin_trip_source_i, .periph_clock_ctrl_reg0_tbsync_i,
    .ram_double_bit_error_i, .interrupt_expander_error_i, .encoder_unit_error_i, .clock_loss_detect_i,
    .debug_halt_i, .period_i, .cmp_a_i, .cmp_b_i, .ustep_a_i, .ustep_b_i, .gen_trip_en_i, .zone_trip_en_i,
    .act_a_i, .act_b_i, .trip_clear_i, .out_a_o, .out_b_o, .oe_a_o, .oe_b_o, .edge_a_o, .edge_b_o,
    .first_module_sync_out_o, .merged_conv_start_a_o, .merged_conv_start_b_o, .conv_start_o,
    .modulator_event_irq_o, .modulator_trip_irq_o);

  pstg_far_model pstg_far_model_i (.sys_clk_i, .rstn_i, .sync_i(first_module_sync_out_o),
    .start_a_i(merged_conv_start_a_o), .start_b_i(merged_conv_start_b_o), .width_o(width));

  // Free-running clock; the ceiling cuts a hang short well beyond the expected run length.
  always #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycle_count++;
    if (cycle_count == 8000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // Source index: 0..11 pins, 12 ECC, 13 expander error, 14..19 zone sources in order.
  task automatic src(int s, logic v);
    if (s < 12) pin_trip_source_i[s] = v;
    else if (s == 12) ram_double_bit_error_i = v;
    else if (s == 13) interrupt_expander_error_i = v;
    else if (s < 17) pin_trip_source_i[s-14] = v;
    else if (s == 17) encoder_unit_error_i = v;
    else if (s == 18) clock_loss_detect_i = v;
    else debug_halt_i = v;
  endtask

  task automatic chk_out(logic [1:0] a, logic o, logic e);
    chk("trip_oe", {31'h0, a != 2'h0}, {31'h0, e});
    if (a != 2'h0) chk("trip_level", {31'h0, a == 2'h1}, {31'h0, o});
  endtask

  // Micro-step offsets: fine modules follow the request below 80, the standard one never does.
  task automatic t_edge();
    ustep_a_i[6:0] = 7'h28;
    ustep_a_i[62:56] = 7'h28;
    ustep_b_i[13:7] = 7'h50;
    ustep_b_i[20:14] = 7'h4f;
    tick(3);
    chk("edge_fine", 32'h28, 32'(edge_a_o[6:0]));
    chk("edge_std", 32'h0, 32'(edge_a_o[62:56]));
    chk("edge_over", 32'h0, 32'(edge_b_o[13:7]));
    chk("edge_top", 32'h4f, 32'(edge_b_o[20:14]));
  endtask

  // One module at a time fires its starts; routing, merge widths and event interrupt are judged.
  task automatic t_conv();
    int t, k;
    logic [17:0] seen;
    for (int m = 0; m < 9; m++) begin
      // One assignment each: every field but module m stays all ones, m compares at 5 and 20.
      cmp_a_i = ~(144'(16'hfffa) << (m*16));
      cmp_b_i = ~(144'(16'hffeb) << (m*16));
      t = 0;
      while (conv_start_o[2*m] !== 1'b1 && t < 200) begin tick(1); t++; end
      chk("conv_a", 32'h1, 32'(conv_start_o[2*m]));
      seen = '0;
      k = 0;
      repeat (62) begin
        tick(1);
        seen |= conv_start_o;
        k += modulator_event_irq_o[m];
      end
      chk("conv_b_only", 32'(18'h1 << (2*m+1)), 32'(seen));
      chk("merged_a_len", 32'd32, 32'(width[1]));
      chk("merged_b_len", 32'd32, 32'(width[2]));
      chk("event_irq", 32'd1, 32'(k));
    end
    cmp_a_i = '1;
    cmp_b_i = '1;
  endtask

  // Starts every 20 cycles keep the stretch alive; the tail is 32 cycles after the last one.
  task automatic t_retrig();
    int n;
    tick(1);
    periph_clock_ctrl_reg0_tbsync_i = 1'b0;
    period_i[15:0] = 16'h0013;
    cmp_a_i[15:0] = 16'h0005;
    tick(1);
    periph_clock_ctrl_reg0_tbsync_i = 1'b1;
    for (int p = 0; p < 3; p++) begin
      n = 0;
      do begin tick(1); n++; end while (conv_start_o[0] !== 1'b1 && n < 100);
      if (p > 0) chk("merged_held", 32'h1, 32'(merged_conv_start_a_o));
    end
    cmp_a_i[15:0] = 16'hffff;
    n = 0;
    do begin tick(1); n++; end while (merged_conv_start_a_o === 1'b1 && n < 100);
    chk("retrig_tail", 32'd33, 32'(n));
    periph_clock_ctrl_reg0_tbsync_i = 1'b0;
    period_i[15:0] = 16'h003f;
    tick(1);
    periph_clock_ctrl_reg0_tbsync_i = 1'b1;
  endtask

  // Time bases held off by the enable give no starts; the external sync yields an 8-cycle sync out.
  task automatic t_sync();
    int n;
    logic [17:0] seen;
    tick(1);
    cmp_a_i[15:0] = 16'h0005;
    periph_clock_ctrl_reg0_tbsync_i = 1'b0;
    seen = '0;
    repeat (130) begin tick(1); seen |= conv_start_o; end
    chk("starts_off", 32'h0, 32'(seen));
    periph_clock_ctrl_reg0_tbsync_i = 1'b1;
    // The enable itself makes a sync; let it die out and sync mid-period so the pulse is ours.
    tick(20);
    pin_trip_source_i[0] = 1'b1;
    tick(1);
    pin_trip_source_i[0] = 1'b0;
    tick(1);
    chk("sync_early", 32'h0, 32'(first_module_sync_out_o));
    tick(1);
    chk("sync_rise", 32'h1, 32'(first_module_sync_out_o));
    n = 0;
    while (first_module_sync_out_o === 1'b1 && n < 20) begin tick(1); n++; end
    chk("sync_ticks", 32'd8, 32'(n));
    tick(1);
    chk("sync_len", 32'd8, 32'(width[0]));
    cmp_a_i[15:0] = 16'hffff;
  endtask

  // Every trip source on module 3 in turn, each forcing action; the latch holds until software clears it.
  task automatic t_trip();
    logic [1:0] aa, ab;
    int k;
    for (int s = 0; s < 20; s++) begin
      aa = 2'(s % 3);
      ab = 2'((s + 1) % 3);
      act_a_i[7:6] = aa;
      act_b_i[7:6] = ab;
      if (s < 14) gen_trip_en_i[45+s] = 1'b1;
      else zone_trip_en_i[18+s-14] = 1'b1;
      tick(1);
      src(s, 1'b1);
      #1;
      chk_out(aa, out_a_o[3], oe_a_o[3]);
      chk_out(ab, out_b_o[3], oe_b_o[3]);
      chk("other_oe", 32'h1, 32'(oe_a_o[4]));
      k = 0;
      repeat (3) begin tick(1); k += modulator_trip_irq_o[3]; end
      chk("trip_irq", 32'd1, 32'(k));
      trip_clear_i[3] = 1'b1;
      tick(1);
      trip_clear_i[3] = 1'b0;
      tick(1);
      chk_out(aa, out_a_o[3], oe_a_o[3]);
      src(s, 1'b0);
      tick(2);
      chk_out(ab, out_b_o[3], oe_b_o[3]);
      trip_clear_i[3] = 1'b1;
      tick(1);
      trip_clear_i[3] = 1'b0;
      gen_trip_en_i = '0;
      zone_trip_en_i = '0;
      tick(1);
      chk("recovered", 32'h3, {30'h0, oe_a_o[3], oe_b_o[3]});
    end
  endtask

  // Main sequence: outputs are checked while reset is held, then each scenario runs in turn.
  initial begin
    tick(3);
    chk("oe_rst", 32'h1ff, 32'(oe_a_o & oe_b_o));
    chk("out_rst", 32'h0, 32'(out_a_o | out_b_o | conv_start_o));
    rstn_i = 1'b1;
    t_edge();
    t_conv();
    t_retrig();
    t_sync();
    t_trip();
    test_done();
  end
endmodule // testbench
`default_nettype wire
